// ---- core/rtccfg_ctrl.sv ----
module rtccfg_ctrl #(
  parameter int DEBOUNCE_CYC = rtccfg_pkg::DEBOUNCE_CYC,
  parameter int CLK_HZ = rtccfg_pkg::CLK_HZ
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic din_i,
  input wire logic battery_low_condition_i,
  input wire logic on_backup_supply_i,
  input wire logic in_sleep_i,
  input wire logic alarm1_irq_i,
  input wire logic [47:0] time_now_i,
  output logic crystal_oscillator_enable_o,
  output logic bus_timeout_enable_o,
  output logic sleep_request_bit_o,
  output logic pin_sleep_request_o,
  output logic din_event_o,
  output logic interrupt_output_a_alarm_o,
  output logic shared_clock_output_pin_o
);
  localparam int DIV32K = CLK_HZ / (2 * rtccfg_pkg::HZ_32K);
  localparam int DIV1K = CLK_HZ / (2 * rtccfg_pkg::HZ_1024);
  localparam int DIV64 = CLK_HZ / (2 * rtccfg_pkg::HZ_64);
  localparam int DIV1 = CLK_HZ / (2 * rtccfg_pkg::HZ_1);
  localparam int DBW = $clog2(DEBOUNCE_CYC + 1);

  rtccfg_stamp_if sif ();

  rtccfg_stamp_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sif(sif)
  );

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] cfg1_r, cfg1_nxt;
  logic [7:0] cfg2_r, cfg2_nxt;
  logic [7:0] tscfg_r, tscfg_nxt;
  logic sreq_r, sreq_nxt;
  logic clr_r, clr_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic in_ts;
  logic [4:0] ts_idx;

  assign in_ts = reg_addr_i >= rtccfg_pkg::ADDR_TSBASE &&
    reg_addr_i < rtccfg_pkg::ADDR_TSBASE + 8'(rtccfg_pkg::TS_BANKS * rtccfg_pkg::TS_BYTES);
  assign ts_idx = 5'(reg_addr_i - rtccfg_pkg::ADDR_TSBASE);

  always_comb
  begin
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    tscfg_nxt = tscfg_r;
    sreq_nxt = sreq_r;
    clr_nxt = 1'b0;
    rdata_nxt = rdata_r;
    tscfg_nxt[rtccfg_pkg::TS_RST] = 1'b0;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        rtccfg_pkg::ADDR_CFG1: cfg1_nxt = reg_wdata_i & rtccfg_pkg::CFG1_MASK;
        rtccfg_pkg::ADDR_CFG2: cfg2_nxt = reg_wdata_i & rtccfg_pkg::CFG2_MASK;
        rtccfg_pkg::ADDR_TSCFG:
        begin
          tscfg_nxt = reg_wdata_i & rtccfg_pkg::TSCFG_MASK;
          clr_nxt = reg_wdata_i[rtccfg_pkg::TS_RST];
        end
        rtccfg_pkg::ADDR_SLPCFG: sreq_nxt = reg_wdata_i[rtccfg_pkg::SLEEP_REQ];
        default: ;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        rtccfg_pkg::ADDR_CFG1: rdata_nxt = cfg1_r;
        rtccfg_pkg::ADDR_CFG2: rdata_nxt = {in_sleep_i, cfg2_r[6:0]};
        rtccfg_pkg::ADDR_TSCFG: rdata_nxt = tscfg_r;
        rtccfg_pkg::ADDR_SLPCFG: rdata_nxt = {sreq_r, 7'h00};
        default: rdata_nxt = in_ts ? sif.rd_data : 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cfg1_r <= rtccfg_pkg::CFG1_RST;
      cfg2_r <= rtccfg_pkg::CFG2_RST;
      tscfg_r <= rtccfg_pkg::TSCFG_RST;
      sreq_r <= 1'b0;
      clr_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      tscfg_r <= tscfg_nxt;
      sreq_r <= sreq_nxt;
      clr_r <= clr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign crystal_oscillator_enable_o = cfg1_r[rtccfg_pkg::CFG1_OSC];
  assign bus_timeout_enable_o = cfg1_r[rtccfg_pkg::CFG1_TMO];
  assign sleep_request_bit_o = sreq_r;

  // ---------------------------------------------------------------
  // Input pin sync, debounce and edge
  // ---------------------------------------------------------------
  logic [1:0] din_s_r, din_s_nxt;
  logic [1:0] vb_s_r, vb_s_nxt;
  logic [1:0] sw_s_r, sw_s_nxt;
  logic db_r, db_nxt;
  logic [DBW-1:0] db_cnt_r, db_cnt_nxt;
  logic din_q_r, din_q_nxt;
  logic vb_q_r, vb_q_nxt;
  logic sw_q_r, sw_q_nxt;
  logic din_use, din_edge, vb_rise, sw_chg;

  // Filter needs the pin stable for the whole window, so glitches restart it
  always_comb
  begin
    din_s_nxt = {din_s_r[0], din_i};
    vb_s_nxt = {vb_s_r[0], battery_low_condition_i};
    sw_s_nxt = {sw_s_r[0], on_backup_supply_i};
    db_nxt = db_r;
    db_cnt_nxt = db_cnt_r;
    if (din_s_r[1] == db_r)
      db_cnt_nxt = '0;
    else if (db_cnt_r == DBW'(DEBOUNCE_CYC - 1))
    begin
      db_nxt = din_s_r[1];
      db_cnt_nxt = '0;
    end
    else
      db_cnt_nxt = db_cnt_r + 1'b1;
    din_use = cfg2_r[rtccfg_pkg::CFG2_DEBOUNCE] ? db_r : din_s_r[1];
    din_q_nxt = din_use;
    vb_q_nxt = vb_s_r[1];
    sw_q_nxt = sw_s_r[1];
    din_edge = cfg1_r[rtccfg_pkg::CFG1_POL] ? (din_use && !din_q_r)
      : (!din_use && din_q_r);
    vb_rise = vb_s_r[1] && !vb_q_r;
    sw_chg = sw_s_r[1] != sw_q_r;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      din_s_r <= 2'h3;
      vb_s_r <= 2'h0;
      sw_s_r <= 2'h0;
      db_r <= 1'b1;
      db_cnt_r <= '0;
      din_q_r <= 1'b1;
      vb_q_r <= 1'b0;
      sw_q_r <= 1'b0;
    end
    else
    begin
      din_s_r <= din_s_nxt;
      vb_s_r <= vb_s_nxt;
      sw_s_r <= sw_s_nxt;
      db_r <= db_nxt;
      db_cnt_r <= db_cnt_nxt;
      din_q_r <= din_q_nxt;
      vb_q_r <= vb_q_nxt;
      sw_q_r <= sw_q_nxt;
    end
  end

  assign din_event_o = din_edge;
  assign pin_sleep_request_o = din_edge && cfg2_r[rtccfg_pkg::CFG2_PIN_SLEEP];

  // ---------------------------------------------------------------
  // Timestamp triggers
  // ---------------------------------------------------------------
  logic cap;
  assign cap = tscfg_r[rtccfg_pkg::TS_EN] && (
    (vb_rise && tscfg_r[rtccfg_pkg::TS_VLOW]) ||
    (sw_chg && tscfg_r[rtccfg_pkg::TS_PWM]) ||
    (din_edge && tscfg_r[rtccfg_pkg::TS_DIN]));
  assign sif.clear = clr_r;
  assign sif.capture = cap;
  assign sif.overwrite = tscfg_r[rtccfg_pkg::TS_OW];
  assign sif.now = time_now_i;
  assign sif.wr_en = reg_wr_i && in_ts;
  assign sif.wr_idx = ts_idx;
  assign sif.wr_data = reg_wdata_i;
  assign sif.rd_idx = ts_idx;

  // ---------------------------------------------------------------
  // Clock output and alarm routing
  // ---------------------------------------------------------------
  logic [31:0] div_r, div_nxt;
  logic clk_r, clk_nxt;
  logic pin_r, pin_nxt;
  logic [31:0] half;

  // 32kHz is a truncated divide of the system clock, not compensated
  always_comb
  begin
    unique case (cfg2_r[rtccfg_pkg::CFG2_HZ_LO +: 2])
      rtccfg_pkg::FREQ_1: half = 32'(DIV1);
      rtccfg_pkg::FREQ_64: half = 32'(DIV64);
      rtccfg_pkg::FREQ_1K: half = 32'(DIV1K);
      rtccfg_pkg::FREQ_32K: half = 32'(DIV32K);
    endcase
    clk_nxt = clk_r;
    div_nxt = div_r + 32'h1;
    if (div_r >= half - 32'h1)
    begin
      div_nxt = 32'h0;
      clk_nxt = !clk_r;
    end
    pin_nxt = cfg2_r[rtccfg_pkg::CFG2_CLKO] ? clk_r : !alarm1_irq_i;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      div_r <= 32'h0;
      clk_r <= 1'b0;
      pin_r <= 1'b1;
    end
    else
    begin
      div_r <= div_nxt;
      clk_r <= clk_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign shared_clock_output_pin_o = pin_r;
  assign interrupt_output_a_alarm_o = cfg2_r[rtccfg_pkg::CFG2_CLKO] && alarm1_irq_i;
endmodule

// ---- core/rtccfg_pkg.sv ----
package rtccfg_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG1 = 8'h03;
  localparam logic [7:0] ADDR_CFG2 = 8'h04;
  localparam logic [7:0] ADDR_TSCFG = 8'h05;
  localparam logic [7:0] ADDR_SLPCFG = 8'h07;
  localparam logic [7:0] ADDR_TSBASE = 8'h10;
  localparam int TS_BYTES = 6;
  localparam int TS_BANKS = 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG1_OSC = 0;
  localparam int CFG1_TMO = 1;
  localparam int CFG1_POL = 3;
  localparam int CFG2_SLEEP_FLAG = 7;
  localparam int CFG2_PIN_SLEEP = 4;
  localparam int CFG2_DEBOUNCE = 3;
  localparam int CFG2_CLKO = 2;
  localparam int CFG2_HZ_LO = 0;
  localparam int TS_VLOW = 5;
  localparam int TS_PWM = 4;
  localparam int TS_DIN = 3;
  localparam int TS_OW = 2;
  localparam int TS_RST = 1;
  localparam int TS_EN = 0;
  localparam int SLEEP_REQ = 7;

  // ---------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG1_RST = 8'h03;
  localparam logic [7:0] CFG2_RST = 8'h03;
  localparam logic [7:0] TSCFG_RST = 8'h04;
  localparam logic [7:0] CFG1_MASK = 8'h0b;
  localparam logic [7:0] CFG2_MASK = 8'h1f;
  localparam logic [7:0] TSCFG_MASK = 8'h3d;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int DEBOUNCE_MS = 50;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int HZ_1 = 1;
  localparam int HZ_64 = 64;
  localparam int HZ_1024 = 1024;
  localparam int HZ_32K = 32768;
  localparam logic [1:0] FREQ_1 = 2'h0;
  localparam logic [1:0] FREQ_64 = 2'h1;
  localparam logic [1:0] FREQ_1K = 2'h2;
  localparam logic [1:0] FREQ_32K = 2'h3;
endpackage

// ---- core/rtccfg_stamp_if.sv ----
interface rtccfg_stamp_if;
  logic clear;
  logic capture;
  logic overwrite;
  logic [47:0] now;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [7:0] wr_data;
  logic [4:0] rd_idx;
  logic [7:0] rd_data;
  logic [2:0] count;
  modport ctrl (output clear, capture, overwrite, now, wr_en, wr_idx, wr_data, rd_idx,
    input rd_data, count);
  modport store (input clear, capture, overwrite, now, wr_en, wr_idx, wr_data, rd_idx,
    output rd_data, count);
endinterface

// ---- core/rtccfg_stamp_store.sv ----
module rtccfg_stamp_store (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  rtccfg_stamp_if.store sif
);
  localparam int NB = rtccfg_pkg::TS_BANKS * rtccfg_pkg::TS_BYTES;

  logic [7:0] mem_r [NB];
  logic [7:0] mem_nxt [NB];
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic full;

  assign full = (cnt_r == 3'(rtccfg_pkg::TS_BANKS));
  assign sif.count = cnt_r;
  assign sif.rd_data = (sif.rd_idx < 5'(NB)) ? mem_r[sif.rd_idx] : 8'h00;

  // ---------------------------------------------------------------
  // Bank shift: bank 0 newest, bank 3 oldest
  // ---------------------------------------------------------------
  always_comb
  begin
    mem_nxt = mem_r;
    cnt_nxt = cnt_r;
    if (sif.clear)
    begin
      for (int i = 0; i < NB; i++)
        mem_nxt[i] = 8'h00;
      cnt_nxt = 3'h0;
    end
    else if (sif.capture && (!full || sif.overwrite))
    begin
      for (int i = NB - 1; i >= rtccfg_pkg::TS_BYTES; i--)
        mem_nxt[i] = mem_r[i - rtccfg_pkg::TS_BYTES];
      for (int i = 0; i < rtccfg_pkg::TS_BYTES; i++)
        mem_nxt[i] = sif.now[i*8 +: 8];
      if (!full)
        cnt_nxt = cnt_r + 3'h1;
    end
    else if (sif.wr_en && sif.wr_idx < 5'(NB))
      mem_nxt[sif.wr_idx] = sif.wr_data;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NB; i++)
        mem_r[i] <= 8'h00;
      cnt_r <= 3'h0;
    end
    else
    begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ---- test/rtccfg_ctrl_monitor.sv ----
module rtccfg_mon (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic in_sleep_i,
  input wire logic alarm1_irq_i,
  input wire logic crystal_oscillator_enable_o,
  input wire logic bus_timeout_enable_o,
  input wire logic sleep_request_bit_o,
  input wire logic pin_sleep_request_o,
  input wire logic din_event_o,
  input wire logic interrupt_output_a_alarm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  AST_OSC: assert property (
    s_wr(8'h03) |=> crystal_oscillator_enable_o == $past(reg_wdata_i[0]))
    else $error("osc enable");
  AST_TMO: assert property (s_wr(8'h03) |=> bus_timeout_enable_o == $past(reg_wdata_i[1]))
    else $error("timeout enable");
  AST_SLEEP_REQ: assert property (
    s_wr(8'h07) |=> sleep_request_bit_o == $past(reg_wdata_i[7]))
    else $error("sleep request");
  AST_SLEEP_FLAG: assert property (
    s_rd(8'h04) |=> reg_rdata_o[7:5] == {$past(in_sleep_i), 2'h0})
    else $error("sleep flag");
  AST_STAMP_RST: assert property (
    s_rd(8'h05) |=> !reg_rdata_o[1] && reg_rdata_o[7:6] == 2'h0)
    else $error("stamp reset bit");
  AST_UNM: assert property (s_rd(8'h08) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read");
  AST_ALMA: assert property (interrupt_output_a_alarm_o |-> alarm1_irq_i)
    else $error("alarm a");
  AST_PSLP: assert property (pin_sleep_request_o |-> din_event_o)
    else $error("pin sleep");
  AST_PULSE: assert property (din_event_o |=> !din_event_o)
    else $error("edge pulse");
endmodule
bind rtccfg_ctrl rtccfg_mon u_mon (.*);

// ---- test/rtccfg_host.sv ----
module rtccfg_host (
  input wire logic sys_clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge sys_clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge sys_clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Idle lines must not look like a held value
    addr_o = ~a;
    wdata_o = ~d;
    q = rdata_i;
  endtask
endmodule

// ---- test/rtccfg_ctrl_tb.sv ----
module rtccfg_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic din = 1'b1, bat = 1'b0, sup = 1'b0, asleep = 1'b0, alm = 1'b0;
  logic [47:0] now = 48'h0;
  logic wr, rd, dev, psr, alma, pin, osc, tmo, sreq;
  logic [7:0] addr, wdata, rdata, q, d, a;
  logic [47:0] exp_q[4];
  int failures = 0, samples_checked = 0, seed = 32'he899, nev = 0, nps = 0, cnt = 0;
  int hz[4] = '{rtccfg_pkg::HZ_1, rtccfg_pkg::HZ_64, rtccfg_pkg::HZ_1024, rtccfg_pkg::HZ_32K};
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    nev += int'(dev === 1'b1);
    nps += int'(psr === 1'b1);
  end
  rtccfg_host h (.sys_clk_i(sys_clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  // Short counts keep debounce and 1Hz output inside the run
  rtccfg_ctrl #(.DEBOUNCE_CYC(8), .CLK_HZ(65536)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .din_i(din), .battery_low_condition_i(bat), .on_backup_supply_i(sup), .in_sleep_i(asleep),
    .alarm1_irq_i(alm), .time_now_i(now), .crystal_oscillator_enable_o(osc),
    .bus_timeout_enable_o(tmo), .sleep_request_bit_o(sreq), .pin_sleep_request_o(psr),
    .din_event_o(dev), .interrupt_output_a_alarm_o(alma), .shared_clock_output_pin_o(pin));
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd8(input logic [7:0] ra, input logic [7:0] e);
    h.xfer(1'b0, ra, 8'h00, q);
    chk(48'(q), 48'(e));
  endtask
  function automatic logic [7:0] rexp(input logic [7:0] ra, input logic [7:0] v);
    if (ra == 8'h03)
      return v & rtccfg_pkg::CFG1_MASK;
    if (ra == 8'h04)
      return {asleep, v[6:0] & 7'h1f};
    return v & rtccfg_pkg::TSCFG_MASK;
  endfunction
  function automatic void push(input logic [47:0] t, input logic ow);
    if (ow || cnt < 4)
    begin
      for (int i = 3; i > 0; i--)
        exp_q[i] = exp_q[i - 1];
      exp_q[0] = t;
      cnt++;
    end
  endfunction
  task automatic wipe(input logic [7:0] v);
    h.xfer(1'b1, 8'h05, v, q);
    exp_q = '{default: 48'h0};
    cnt = 0;
  endtask
  task automatic ev(input int k, input logic ow);
    @(negedge sys_clk_i);
    now = 48'({$random(seed), $random(seed)});
    din = (k != 0);
    sup = (k == 1) ? ~sup : sup;
    bat = (k == 2);
    repeat (12) @(negedge sys_clk_i);
    din = 1'b1;
    bat = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    push(now, ow);
  endtask
  task automatic banks;
    logic [47:0] v;
    for (int b = 0; b < 4; b++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        h.xfer(1'b0, 8'(8'h10 + 6 * b + k), 8'h00, q);
        v[8 * k +: 8] = q;
      end
      chk(v, exp_q[b]);
    end
  endtask
  task automatic per(input logic [1:0] f, input int e);
    logic p;
    int n;
    h.xfer(1'b1, 8'h04, {6'h01, f}, q);
    for (int s = 0; s < 2; s++)
    begin
      p = pin;
      // Look away from the edge that moves the pin
      for (n = 0; n < 70000 && pin === p; n++)
        @(negedge sys_clk_i);
    end
    chk(48'(n >= e - 1 && n <= e + 1), 48'h1);
  endtask
  task automatic pins(input int c, input logic v);
    din = v;
    repeat (c) @(negedge sys_clk_i);
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(negedge sys_clk_i);
    rst_i = 1'b0;
    chk(48'({osc, tmo, pin}), 48'h7);
    rd8(8'h03, rtccfg_pkg::CFG1_RST);
    rd8(8'h04, rtccfg_pkg::CFG2_RST);
    rd8(8'h05, rtccfg_pkg::TSCFG_RST);
    for (int i = 0; i < 24; i++)
    begin
      d = 8'($random(seed));
      asleep = d[0];
      a = 8'h03 + 8'(i % 3);
      h.xfer(1'b1, a, d, q);
      if (a == 8'h03)
        chk(48'({osc, tmo}), 48'({d[0], d[1]}));
      rd8(a, rexp(a, d));
    end
    h.xfer(1'b1, 8'h07, 8'h80, q);
    chk(48'(sreq), 48'h1);
    h.xfer(1'b1, 8'h08, 8'hff, q);
    rd8(8'h08, 8'h00);
    h.xfer(1'b1, 8'h04, 8'h00, q);
    alm = 1'b1;
    @(negedge sys_clk_i);
    chk(48'({alma, pin}), 48'h0);
    h.xfer(1'b1, 8'h04, 8'h04, q);
    chk(48'(alma), 48'h1);
    alm = 1'b0;
    for (int f = 0; f < 4; f++)
      per(2'(f), 65536 / (2 * hz[f]));
    h.xfer(1'b1, 8'h03, 8'h03, q);
    h.xfer(1'b1, 8'h04, 8'h18, q);
    nev = 0;
    nps = 0;
    pins(3, 1'b0);
    pins(20, 1'b1);
    chk(48'(nev), 48'h0);
    pins(30, 1'b0);
    pins(30, 1'b1);
    chk(48'({nev, nps}), 48'({32'h1, 32'h1}));
    h.xfer(1'b1, 8'h04, 8'h00, q);
    h.xfer(1'b1, 8'h03, 8'h0b, q);
    pins(6, 1'b0);
    chk(48'(nev), 48'h1);
    pins(6, 1'b1);
    chk(48'({nev, nps}), 48'({32'h2, 32'h1}));
    h.xfer(1'b1, 8'h03, 8'h03, q);
    wipe(8'h3b);
    for (int i = 0; i < 5; i++)
      ev(i % 3, 1'b0);
    banks;
    wipe(8'h3f);
    banks;
    for (int i = 0; i < 6; i++)
      ev(i % 3, 1'b1);
    banks;
    wipe(8'h02);
    h.xfer(1'b1, 8'h10, 8'ha5, q);
    ev(0, 1'b0);
    exp_q[0] = 48'ha5;
    banks;
    end_of_test;
  end
endmodule
